// file: hdl/temp_i2c_pkg.sv
package temp_i2c_pkg;

  localparam int CLK_MHZ        = 100;
  localparam int CLK_PERIOD_NS  = 10;

  // Input spike filter: a level must persist this long before it is taken.
  localparam int SPIKE_NS       = 50;
  localparam int SPIKE_CYCLES   = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // External reset pin: least low time that counts as a reset.
  localparam int RESET_MIN_NS   = 1000;
  localparam int RESET_CYCLES   = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Bus stall limit on SDA held low, least and longest time.
  localparam int STALL_MIN_MS   = 150;
  localparam int STALL_MAX_MS   = 300;
  localparam int STALL_CYCLES   = STALL_MIN_MS * CLK_MHZ * 1000;

  // Target address layout.
  localparam logic [3:0] ADDR_FIXED_HI  = 4'h9;
  localparam logic [1:0] VAR_THREE_SEL  = 2'h0;
  localparam logic [1:0] VAR_TWO_SEL_HI = 2'h1;
  localparam logic [1:0] VAR_TWO_SEL_LO = 2'h2;

  // Register pointer values.
  localparam logic [1:0] PTR_TEMP = 2'h0;
  localparam logic [1:0] PTR_CFG  = 2'h1;
  localparam logic [1:0] PTR_HYST = 2'h2;
  localparam logic [1:0] PTR_OS   = 2'h3;

  // Power-on values; limits are 9-bit two's complement at 0.5 degree per step.
  localparam logic [7:0] CFG_RST  = 8'h00;
  localparam logic [8:0] HYST_RST = 9'h096;
  localparam logic [8:0] OS_RST   = 9'h0a0;
  localparam logic [8:0] TEMP_RST = 9'h000;
  localparam logic [1:0] PTR_RST  = 2'h0;

  // Configuration field positions.
  localparam int CFG_SD    = 0;
  localparam int CFG_INT   = 1;
  localparam int CFG_POL   = 2;
  localparam int CFG_FQ_LO = 3;
  localparam int CFG_FQ_HI = 4;

  typedef enum logic [1:0] {
    XFER_WRITE_BYTE,
    XFER_READ_BYTE,
    XFER_SEND_BYTE,
    XFER_RECV_BYTE
  } xfer_kind_t;

  // Host serial clock rate and its quarter-period in system clocks.
  localparam int HOST_SCL_KHZ    = 100;
  localparam int HOST_QTR_CYCLES = CLK_MHZ * 1000 / (HOST_SCL_KHZ * 4);

endpackage

// file: hdl/temp_i2c_if.sv
`timescale 1ns/1ps
interface temp_i2c_if;
  logic scl_host_o;
  logic scl_host_oe;
  logic sda_host_o;
  logic sda_host_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic alarm_o;
  logic alarm_oe;
  logic scl;
  logic sda;
  logic alarm;

  // Wired-AND with pull-ups: a line is low while any enabled driver drives low.
  assign scl   = ~(scl_host_oe & ~scl_host_o);
  assign sda   = ~((sda_host_oe & ~sda_host_o) | (sda_dev_oe & ~sda_dev_o));
  assign alarm = ~(alarm_oe & ~alarm_o);

  modport dev  (input scl, input sda, output sda_dev_o, output sda_dev_oe,
                output alarm_o, output alarm_oe);
  modport host (input scl, input sda, input alarm, output scl_host_o,
                output scl_host_oe, output sda_host_o, output sda_host_oe);
endinterface

// file: hdl/temp_sensor_i2c_target_port.sv
// Overview of operation
// R1: Three-pin variant answers 1001 plus three pins.
// R2: Two-pin variants fix bit 3, two pins.
// R3: Address comes from strapped select pins.
// R4: Select pins are tied, never left floating.
// R5: Only write, read, send, receive byte forms.
// R6: Receive byte returns the last pointed register.
// R7: Multiple controllers beware pointer changed by others.
// R8: State appears as byte-wide registers.
// R9: SDA low past stall limit frees bus.
// R10: Reset pin low 1 us restores everything.
// R11: Pin pulses under 50 ns are ignored.
// R12: Alarm needs consecutive over-limit conversions, six max.
// R13: Temperature read anytime returns last result.
// R14: Thresholds and configuration load defaults at reset.
// R15: Alarm and SDA only pull low.
// R16: Fault bits select 1, 2, 4 or 6.
// R17: Interrupt mode alarm holds until any read; the code also clears it while the shutdown bit is set.
// R18: First written byte is pointer, rest data.
// R19: Conversion result arrives parallel with strobe.
`timescale 1ns/1ps
module temp_sensor_i2c_target_port
  import temp_i2c_pkg::*;
#(
  parameter logic [1:0] VARIANT     = VAR_THREE_SEL,
  parameter int         STALL_LIMIT = STALL_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  temp_i2c_if.dev         bus,
  input  wire logic       addr_sel_0,
  input  wire logic       addr_sel_1,
  input  wire logic       addr_sel_2,
  input  wire logic       ext_reset_n,
  input  wire logic [8:0] conv_data,
  input  wire logic       conv_valid,
  output logic            shutdown_out,
  output logic            overtemp_alarm_out
);

  localparam int                 NPIN      = 6;
  localparam logic [NPIN-1:0]    PIN_IDLE  = 6'h3f;
  localparam logic [2:0]         FILT_LAST = 3'(SPIKE_CYCLES - 1);
  localparam logic [6:0]         RST_LAST  = 7'(RESET_CYCLES - 1);
  localparam logic [23:0]        STALL_LAST = 24'(STALL_LIMIT - 1);

  typedef enum {S_IDLE, S_RX, S_RX_ACK, S_TX, S_TX_ACK} state_t;

  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] sync1_r;
  logic [NPIN-1:0] sync2_r;
  logic [NPIN-1:0] filt_r;
  logic [2:0]      fcnt_r [NPIN];
  logic            sda_f;
  logic            scl_f;
  logic            rstpin_f;
  logic            sda_d_r;
  logic            scl_d_r;
  logic [6:0]      rlow_cnt_r;
  logic            soft_rst_r;
  logic [23:0]     stall_cnt_r;
  logic            stall_hit;
  state_t          state_r;
  logic [2:0]      bitcnt_r;
  logic            full_r;
  logic [1:0]      fb_r;
  logic            rw_r;
  logic            rb_r;
  logic [7:0]      shift_r;
  logic [7:0]      tx_r;
  logic            sda_oe_r;
  logic [1:0]      ptr_r;
  logic [7:0]      cfg_r;
  logic [8:0]      hyst_r;
  logic [8:0]      os_r;
  logic [8:0]      temp_r;
  logic [15:0]     snap_r;
  logic [15:0]     snap_src;
  logic [7:0]      tx_src;
  logic [2:0]      fault_cnt_r;
  logic [2:0]      fault_need;
  logic            seek_low_r;
  logic            alarm_act_r;
  logic            alarm_oe_r;

  assign pin_raw = {ext_reset_n, addr_sel_2, addr_sel_1, addr_sel_0, bus.scl, bus.sda};

  // Every pin is synchronised, then must hold its new level for the spike window.
  generate
    for (genvar gi = 0; gi < NPIN; gi++) begin : g_pin
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          sync1_r[gi] <= PIN_IDLE[gi];
          sync2_r[gi] <= PIN_IDLE[gi];
          filt_r[gi]  <= PIN_IDLE[gi];
          fcnt_r[gi]  <= 3'h0;
        end else begin
          sync1_r[gi] <= pin_raw[gi];
          sync2_r[gi] <= sync1_r[gi];
          if (sync2_r[gi] == filt_r[gi]) begin
            fcnt_r[gi] <= 3'h0;
          end else if (fcnt_r[gi] == FILT_LAST) begin
            filt_r[gi] <= sync2_r[gi]; // R11
            fcnt_r[gi] <= 3'h0;
          end else begin
            fcnt_r[gi] <= fcnt_r[gi] + 3'h1;
          end
        end
      end
    end
  endgenerate

  assign sda_f    = filt_r[0];
  assign scl_f    = filt_r[1];
  assign rstpin_f = filt_r[5];

  wire       scl_rise = scl_f & ~scl_d_r;
  wire       scl_fall = ~scl_f & scl_d_r;
  wire       start_det = scl_f & scl_d_r & sda_d_r & ~sda_f;
  wire       stop_det  = scl_f & scl_d_r & ~sda_d_r & sda_f;
  wire       bit3 = (VARIANT == VAR_THREE_SEL) ? filt_r[4] : (VARIANT == VAR_TWO_SEL_HI); // R1 R2
  wire [6:0] my_addr = {ADDR_FIXED_HI, bit3, filt_r[3], filt_r[2]}; // R1 R3
  wire       byte_done = (state_r == S_RX) & scl_fall & full_r;
  wire       addr_hit = (shift_r[7:1] == my_addr);
  wire       wr_evt = byte_done & (fb_r != 2'h0); // R18
  wire       rd_evt = byte_done & (fb_r == 2'h0) & addr_hit & shift_r[0]; // R5

  assign stall_hit = ~sda_f & (stall_cnt_r == STALL_LAST);
  assign tx_src    = rb_r ? snap_r[7:0] : snap_r[15:8];

  // Reads return the pointed register; receive byte reuses the stored pointer.
  always_comb begin
    case (ptr_r) // R6 R8
      PTR_TEMP: snap_src = {temp_r, 7'h00}; // R13
      PTR_CFG:  snap_src = {cfg_r, cfg_r};
      PTR_HYST: snap_src = {hyst_r, 7'h00};
      default:  snap_src = {os_r, 7'h00};
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_d_r     <= 1'b1;
      sda_d_r     <= 1'b1;
      rlow_cnt_r  <= 7'h00;
      soft_rst_r  <= 1'b0;
      stall_cnt_r <= 24'h000000;
    end else begin
      scl_d_r     <= scl_f;
      sda_d_r     <= sda_f;
      rlow_cnt_r  <= (rstpin_f || rlow_cnt_r == RST_LAST) ? 7'h00 : rlow_cnt_r + 7'h01;
      soft_rst_r  <= ~rstpin_f & (soft_rst_r | (rlow_cnt_r == RST_LAST)); // R10
      stall_cnt_r <= (sda_f || stall_hit) ? 24'h000000 : stall_cnt_r + 24'h000001; // R9
    end
  end

  // Serial engine: bits are taken on SCL rising, SDA changes after SCL falling.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r  <= S_IDLE;
      bitcnt_r <= 3'h0;
      full_r   <= 1'b0;
      fb_r     <= 2'h0;
      rw_r     <= 1'b0;
      rb_r     <= 1'b0;
      shift_r  <= 8'h00;
      tx_r     <= 8'h00;
      sda_oe_r <= 1'b0;
    end else if (soft_rst_r || stall_hit) begin
      state_r  <= S_IDLE; // R9 R10
      sda_oe_r <= 1'b0;
      full_r   <= 1'b0;
    end else if (start_det) begin
      state_r  <= S_RX;
      bitcnt_r <= 3'h0;
      full_r   <= 1'b0;
      fb_r     <= 2'h0;
      sda_oe_r <= 1'b0;
    end else if (stop_det) begin
      state_r  <= S_IDLE;
      sda_oe_r <= 1'b0;
    end else begin
      case (state_r)
        S_RX: begin
          if (scl_rise) begin
            shift_r  <= {shift_r[6:0], sda_f};
            bitcnt_r <= bitcnt_r + 3'h1;
            full_r   <= (bitcnt_r == 3'h7);
          end else if (byte_done) begin
            full_r <= 1'b0;
            fb_r   <= (fb_r == 2'h3) ? 2'h3 : fb_r + 2'h1;
            if (fb_r == 2'h0 && !addr_hit) begin
              state_r <= S_IDLE; // R3
            end else begin
              sda_oe_r <= 1'b1;
              state_r  <= S_RX_ACK;
              if (fb_r == 2'h0) begin
                rw_r <= shift_r[0];
                rb_r <= 1'b0;
              end
            end
          end
        end
        S_RX_ACK: begin
          if (scl_fall && rw_r) begin
            state_r  <= S_TX;
            sda_oe_r <= ~tx_src[7];
            tx_r     <= {tx_src[6:0], 1'b0};
            rb_r     <= ~rb_r;
          end else if (scl_fall) begin
            sda_oe_r <= 1'b0;
            state_r  <= S_RX;
          end
        end
        S_TX: begin
          if (scl_rise) begin
            bitcnt_r <= bitcnt_r + 3'h1;
            full_r   <= (bitcnt_r == 3'h7);
          end else if (scl_fall && full_r) begin
            full_r   <= 1'b0;
            sda_oe_r <= 1'b0;
            state_r  <= S_TX_ACK;
          end else if (scl_fall) begin
            sda_oe_r <= ~tx_r[7];
            tx_r     <= {tx_r[6:0], 1'b0};
          end
        end
        S_TX_ACK: begin
          if (scl_rise && sda_f) begin
            state_r <= S_IDLE;
          end else if (scl_fall) begin
            state_r  <= S_TX;
            sda_oe_r <= ~tx_src[7];
            tx_r     <= {tx_src[6:0], 1'b0};
            rb_r     <= ~rb_r;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // Register file; the snapshot freezes the read value for the whole transfer.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_r  <= PTR_RST;
      cfg_r  <= CFG_RST; // R14
      hyst_r <= HYST_RST;
      os_r   <= OS_RST;
      temp_r <= TEMP_RST;
      snap_r <= 16'h0000;
    end else if (soft_rst_r) begin
      ptr_r  <= PTR_RST; // R10
      cfg_r  <= CFG_RST;
      hyst_r <= HYST_RST;
      os_r   <= OS_RST;
      temp_r <= TEMP_RST;
      snap_r <= 16'h0000;
    end else begin
      if (conv_valid) begin
        temp_r <= conv_data; // R19 R13
      end
      if (rd_evt) begin
        snap_r <= snap_src;
      end
      if (wr_evt && fb_r == 2'h1) begin
        ptr_r <= shift_r[1:0]; // R18
      end else if (wr_evt && fb_r == 2'h2) begin
        case (ptr_r)
          PTR_CFG:  cfg_r       <= {3'h0, shift_r[4:0]};
          PTR_HYST: hyst_r[8:1] <= shift_r;
          PTR_OS:   os_r[8:1]   <= shift_r;
          default:  cfg_r       <= cfg_r;
        endcase
      end else if (wr_evt && fb_r == 2'h3) begin
        case (ptr_r)
          PTR_HYST: hyst_r[0] <= shift_r[7];
          PTR_OS:   os_r[0]   <= shift_r[7];
          default:  cfg_r     <= cfg_r;
        endcase
      end
    end
  end

  // Fault queue depth.
  always_comb begin
    case (cfg_r[CFG_FQ_HI:CFG_FQ_LO]) // R16
      2'h0:    fault_need = 3'h1;
      2'h1:    fault_need = 3'h2;
      2'h2:    fault_need = 3'h4;
      default: fault_need = 3'h6;
    endcase
  end

  wire over_lim  = $signed(conv_data) > $signed(os_r);
  wire under_lim = $signed(conv_data) < $signed(hyst_r);
  wire fault_now = seek_low_r ? under_lim : over_lim;
  wire trip      = conv_valid & fault_now & (fault_cnt_r + 3'h1 >= fault_need); // R12

  // After a trip the engine looks for the opposite crossing; in comparator mode
  // that tracks the alarm level, in interrupt mode a read or the shutdown bit clears the level only.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_cnt_r <= 3'h0;
      seek_low_r  <= 1'b0;
      alarm_act_r <= 1'b0;
      alarm_oe_r  <= 1'b0;
    end else if (soft_rst_r) begin
      fault_cnt_r <= 3'h0;
      seek_low_r  <= 1'b0;
      alarm_act_r <= 1'b0;
      alarm_oe_r  <= 1'b0;
    end else begin
      if (conv_valid) begin
        fault_cnt_r <= (fault_now && !trip) ? fault_cnt_r + 3'h1 : 3'h0;
      end
      if (trip) begin
        seek_low_r  <= ~seek_low_r;
        alarm_act_r <= cfg_r[CFG_INT] | ~seek_low_r; // R12
      end else if (cfg_r[CFG_INT] && (rd_evt || cfg_r[CFG_SD])) begin
        alarm_act_r <= 1'b0; // R17
      end
      alarm_oe_r <= alarm_act_r ^ cfg_r[CFG_POL]; // R15
    end
  end

  assign bus.sda_dev_o    = 1'b0; // R15
  assign bus.sda_dev_oe   = sda_oe_r;
  assign bus.alarm_o      = 1'b0;
  assign bus.alarm_oe     = alarm_oe_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shutdown_out       <= 1'b0;
      overtemp_alarm_out <= 1'b0;
    end else begin
      shutdown_out       <= cfg_r[CFG_SD];
      overtemp_alarm_out <= alarm_act_r;
    end
  end

endmodule // temp_sensor_i2c_target_port

// file: hdl/temp_i2c_controller.sv
`timescale 1ns/1ps
module temp_i2c_controller
  import temp_i2c_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  temp_i2c_if.host         bus,
  input  wire logic        cmd_valid,
  input  wire xfer_kind_t  cmd_kind,
  input  wire logic [6:0]  cmd_addr,
  input  wire logic [7:0]  cmd_ptr,
  input  wire logic [15:0] cmd_wdata,
  input  wire logic        cmd_two,
  output logic             cmd_ready,
  output logic             done,
  output logic             nack,
  output logic [15:0]      rdata,
  output logic             alarm_seen
);

  localparam logic [7:0] QTR_LAST = 8'(HOST_QTR_CYCLES - 1);

  typedef enum {A_START, A_AW, A_AR, A_PTR, A_WD, A_RD, A_STOP} act_t;

  logic        sda_s1_r;
  logic        sda_s_r;
  logic        al_s1_r;
  logic [7:0]  qcnt_r;
  logic        run_r;
  logic        abort_r;
  xfer_kind_t  kind_r;
  logic [6:0]  addr_r;
  logic [7:0]  ptr_r;
  logic [15:0] wdata_r;
  logic        two_r;
  logic [2:0]  step_r;
  logic [1:0]  ph_r;
  logic [3:0]  bit_r;
  logic        dcnt_r;
  logic [8:0]  rx_r;
  logic        scl_oe_r;
  logic        sda_oe_r;
  act_t        act;
  logic [8:0]  tx9;

  wire tick      = (qcnt_r == QTR_LAST);
  wire last_data = ~two_r | dcnt_r;
  wire is_byte   = (act != A_START) && (act != A_STOP);
  wire item_end  = tick & (ph_r == 2'h3) & (!is_byte || bit_r == 4'h8);

  // Item sequence for each of the four transfer forms.
  always_comb begin
    act = A_STOP;
    if (!abort_r) begin
      case (kind_r) // R5
        XFER_WRITE_BYTE: act = (step_r == 3'h0) ? A_START : (step_r == 3'h1) ? A_AW :
                               (step_r == 3'h2) ? A_PTR : (step_r == 3'h3) ? A_WD : A_STOP;
        XFER_READ_BYTE:  act = (step_r == 3'h0) ? A_START : (step_r == 3'h1) ? A_AW :
                               (step_r == 3'h2) ? A_PTR : (step_r == 3'h3) ? A_START :
                               (step_r == 3'h4) ? A_AR : (step_r == 3'h5) ? A_RD : A_STOP;
        XFER_SEND_BYTE:  act = (step_r == 3'h0) ? A_START : (step_r == 3'h1) ? A_AW :
                               (step_r == 3'h2) ? A_PTR : A_STOP;
        default:         act = (step_r == 3'h0) ? A_START : (step_r == 3'h1) ? A_AR :
                               (step_r == 3'h2) ? A_RD : A_STOP; // R7
      endcase
    end
  end

  always_comb begin
    case (act)
      A_AW:    tx9 = {addr_r, 1'b0, 1'b1};
      A_AR:    tx9 = {addr_r, 1'b1, 1'b1};
      A_PTR:   tx9 = {ptr_r, 1'b1};
      A_WD:    tx9 = {dcnt_r ? wdata_r[7:0] : wdata_r[15:8], 1'b1};
      A_RD:    tx9 = {8'hff, last_data};
      default: tx9 = 9'h1ff;
    endcase
  end

  wire tx_bit = tx9[4'h8 - bit_r];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_s1_r   <= 1'b1;
      sda_s_r    <= 1'b1;
      al_s1_r    <= 1'b1;
      alarm_seen <= 1'b0;
      qcnt_r     <= 8'h00;
    end else begin
      sda_s1_r   <= bus.sda;
      sda_s_r    <= sda_s1_r;
      al_s1_r    <= bus.alarm;
      alarm_seen <= ~al_s1_r;
      qcnt_r     <= (tick || !run_r) ? 8'h00 : qcnt_r + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_r <= 1'b0; abort_r <= 1'b0; kind_r <= XFER_WRITE_BYTE;
      addr_r <= 7'h00; ptr_r <= 8'h00; wdata_r <= 16'h0000; two_r <= 1'b0;
      step_r <= 3'h0; ph_r <= 2'h0; bit_r <= 4'h0; dcnt_r <= 1'b0; rx_r <= 9'h000;
      scl_oe_r <= 1'b0; sda_oe_r <= 1'b0; cmd_ready <= 1'b1; done <= 1'b0;
      nack <= 1'b0; rdata <= 16'h0000;
    end else begin
      done <= 1'b0;
      if (!run_r && cmd_valid) begin
        run_r <= 1'b1; abort_r <= 1'b0; kind_r <= cmd_kind; addr_r <= cmd_addr;
        ptr_r <= cmd_ptr; wdata_r <= cmd_wdata; two_r <= cmd_two; step_r <= 3'h0;
        ph_r <= 2'h0; bit_r <= 4'h0; dcnt_r <= 1'b0; nack <= 1'b0; cmd_ready <= 1'b0;
      end else if (run_r && tick) begin
        ph_r <= ph_r + 2'h1;
        case (ph_r)
          2'h0: sda_oe_r <= (act == A_START) ? 1'b0 : (act == A_STOP) ? 1'b1 : ~tx_bit;
          2'h1: scl_oe_r <= 1'b0;
          2'h2: begin
            if (act == A_START) sda_oe_r <= 1'b1;
            else if (act == A_STOP) sda_oe_r <= 1'b0;
            else rx_r <= {rx_r[7:0], sda_s_r};
          end
          default: begin
            if (act != A_STOP) scl_oe_r <= 1'b1;
            if (is_byte && bit_r != 4'h8) bit_r <= bit_r + 4'h1;
          end
        endcase
        if (item_end) begin
          bit_r <= 4'h0;
          if (act == A_STOP) begin
            run_r <= 1'b0; cmd_ready <= 1'b1; done <= 1'b1;
          end else if (act != A_RD && act != A_START && rx_r[0]) begin
            abort_r <= 1'b1; nack <= 1'b1;
          end else if ((act == A_WD || act == A_RD) && !last_data) begin
            dcnt_r <= 1'b1;
          end else begin
            step_r <= step_r + 3'h1; dcnt_r <= 1'b0;
          end
          if (act == A_RD) rdata <= dcnt_r ? {rdata[15:8], rx_r[8:1]} : {rx_r[8:1], 8'h00};
        end
      end
    end
  end

  assign bus.scl_host_o  = 1'b0;
  assign bus.scl_host_oe = scl_oe_r;
  assign bus.sda_host_o  = 1'b0;
  assign bus.sda_host_oe = sda_oe_r;

endmodule // temp_i2c_controller

// file: sim/temp_i2c_monitor.sv
`timescale 1ns/1ps
module temp_i2c_monitor #(
  parameter int STALL_LIMIT = 2000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe,
  input wire logic alarm_o,
  input wire logic alarm_oe,
  input wire logic scl,
  input wire logic sda
);
  localparam int STALL_MARGIN = 32;
  int stall_cnt_r;
  int stall_cnt_nxt;

  // The count saturates, so a line stuck low for good cannot wrap it back to zero.
  assign stall_cnt_nxt = sda ? 0 :
                         (stall_cnt_r < STALL_LIMIT + STALL_MARGIN) ? stall_cnt_r + 1 : stall_cnt_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stall_cnt_r <= 0;
    end else begin
      stall_cnt_r <= stall_cnt_nxt;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // The margin covers the pin filter delay before the device starts its own count.
  property p_stall_release;
    stall_cnt_r >= STALL_LIMIT + 24 |-> !sda_dev_oe;
  endproperty
  a_stall_release: assert property (p_stall_release)
    else $error("device still pulls sda after the stall limit");
  property p_sda_od;
    sda_dev_oe |-> sda_dev_o == 1'b0;
  endproperty
  a_sda_od: assert property (p_sda_od)
    else $error("device drives sda high");
  property p_alarm_od;
    alarm_oe |-> alarm_o == 1'b0;
  endproperty
  a_alarm_od: assert property (p_alarm_od)
    else $error("device drives the alarm pin high");
  property p_ack_in_low;
    $rose(sda_dev_oe) |-> !scl [*8];
  endproperty
  a_ack_in_low: assert property (p_ack_in_low)
    else $error("device took sda outside the clock low phase");
  property p_ack_hold;
    $rose(sda_dev_oe) |=> sda_dev_oe [*8];
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("device let go of sda too soon");
  property p_stable_high;
    scl && $past(scl) && stall_cnt_r < STALL_LIMIT |-> $stable(sda_dev_oe);
  endproperty
  a_stable_high: assert property (p_stable_high)
    else $error("device moved sda while the clock was high");
  property p_reset_quiet;
    $rose(rst_n) |-> !sda_dev_oe && !alarm_oe ##1 !sda_dev_oe [*8];
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("device pulls a line right after reset");
  property p_alarm_settle;
    $rose(alarm_oe) |=> alarm_oe [*4];
  endproperty
  a_alarm_settle: assert property (p_alarm_settle)
    else $error("alarm pin glitched");
endmodule // temp_i2c_monitor

// file: sim/testbench.sv
`timescale 1ns/1ps
module testbench import temp_i2c_pkg::*;;
  // Above the longest legal low run of the tests (seven bits), below an all-zero pointer byte.
  localparam int         STALL_SIM = 8000;
  localparam logic [6:0] DEV_ADDR  = {ADDR_FIXED_HI, 3'h5};
  logic        clk;
  logic        rst_n;
  logic        cmd_valid;
  xfer_kind_t  cmd_kind;
  logic [6:0]  cmd_addr;
  logic [7:0]  cmd_ptr;
  logic [15:0] cmd_wdata;
  logic        cmd_ready;
  logic        done;
  logic        nack;
  logic [15:0] rdata;
  logic        alarm_seen;
  logic [8:0]  conv_data;
  logic        conv_valid;
  logic        ext_reset_n;
  logic        shutdown_out;
  logic        overtemp_alarm_out;
  int          n_errors;
  int          n_checks;

  temp_i2c_if bus_if();
  temp_i2c_controller i_temp_i2c_controller (.clk(clk), .rst_n(rst_n), .bus(bus_if),
    .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_ptr(cmd_ptr),
    .cmd_wdata(cmd_wdata), .cmd_two(1'b0), .cmd_ready(cmd_ready), .done(done),
    .nack(nack), .rdata(rdata), .alarm_seen(alarm_seen));
  // Straps select 101, one of the eight addresses of the three pin build.
  temp_sensor_i2c_target_port #(.VARIANT(VAR_THREE_SEL), .STALL_LIMIT(STALL_SIM))
    i_temp_sensor_i2c_target_port (.clk(clk), .rst_n(rst_n), .bus(bus_if),
    .addr_sel_0(1'b1), .addr_sel_1(1'b0), .addr_sel_2(1'b1),
    .ext_reset_n(ext_reset_n),
    .conv_data(conv_data), .conv_valid(conv_valid), .shutdown_out(shutdown_out),
    .overtemp_alarm_out(overtemp_alarm_out));
  temp_i2c_monitor #(.STALL_LIMIT(STALL_SIM)) i_temp_i2c_monitor (.clk(clk), .rst_n(rst_n),
    .sda_dev_o(bus_if.sda_dev_o), .sda_dev_oe(bus_if.sda_dev_oe), .alarm_o(bus_if.alarm_o),
    .alarm_oe(bus_if.alarm_oe), .scl(bus_if.scl), .sda(bus_if.sda));

  always #5 clk = ~clk;

  task automatic check1(string what, logic exp, logic got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic check16(string what, logic [15:0] exp, logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // A whole transfer takes tens of thousands of cycles, so the wait bound is generous.
  task automatic xfer(xfer_kind_t k, logic [6:0] a, logic [7:0] p, logic [15:0] w);
    int i;
    @(posedge clk);
    #1;
    cmd_kind = k;
    cmd_addr = a;
    cmd_ptr = p;
    cmd_wdata = w;
    cmd_valid = 1'b1;
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    for (i = 0; i < 60000; i++) begin
      @(posedge clk);
      #1;
      if (done === 1'b1) break;
    end
    check1("transfer done", 1'b1, done);
  endtask

  task automatic conv(logic [8:0] t);
    @(posedge clk);
    #1;
    conv_data = t;
    conv_valid = 1'b1;
    @(posedge clk);
    #1;
    conv_valid = 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic t_wrong_addr();
    xfer(XFER_RECV_BYTE, DEV_ADDR ^ 7'h01, 8'h00, 16'h0000);
    check1("nack wrong address", 1'b1, nack);
    $display("test wrong_addr done");
  endtask

  task automatic t_temp_read();
    conv(9'h0b0);
    check1("alarm at one fault", 1'b1, overtemp_alarm_out);
    check1("alarm pin low", 1'b0, bus_if.alarm);
    xfer(XFER_RECV_BYTE, DEV_ADDR, 8'h00, 16'h0000);
    check1("nack own address", 1'b0, nack);
    check16("temperature", 16'h5800, rdata);
    $display("test temp_read done");
  endtask

  task automatic t_fault_six();
    int i;
    conv(9'h080);
    check1("alarm below hysteresis", 1'b0, overtemp_alarm_out);
    xfer(XFER_WRITE_BYTE, DEV_ADDR, 8'h01, 16'h1919);
    check1("nack config write", 1'b0, nack);
    check1("shutdown bit set", 1'b1, shutdown_out);
    for (i = 0; i < 5; i++) begin
      conv(9'h0b0);
    end
    check1("alarm after five faults", 1'b0, overtemp_alarm_out);
    conv(9'h0b0);
    check1("alarm after six faults", 1'b1, overtemp_alarm_out);
    check1("alarm seen by host", 1'b1, alarm_seen);
    $display("test fault_six done");
  endtask

  task automatic t_cfg_read();
    xfer(XFER_RECV_BYTE, DEV_ADDR, 8'h00, 16'h0000);
    check16("config by kept pointer", 16'h1900, rdata);
    $display("test cfg_read done");
  endtask

  task automatic t_ext_reset();
    @(posedge clk);
    #1;
    ext_reset_n = 1'b0;
    repeat (40) @(posedge clk);
    #1;
    ext_reset_n = 1'b1;
    repeat (20) @(posedge clk);
    #1;
    check1("alarm kept after short pulse", 1'b1, overtemp_alarm_out);
    ext_reset_n = 1'b0;
    repeat (150) @(posedge clk);
    #1;
    ext_reset_n = 1'b1;
    repeat (20) @(posedge clk);
    #1;
    check1("alarm cleared by reset pin", 1'b0, overtemp_alarm_out);
    check1("shutdown cleared by reset pin", 1'b0, shutdown_out);
    $display("test ext_reset done");
  endtask

  // An all-zero pointer keeps SDA low past the stall limit, so the device drops its acknowledge.
  task automatic t_stall();
    xfer(XFER_READ_BYTE, DEV_ADDR, 8'h00, 16'h0000);
    check1("nack after sda held low", 1'b1, nack);
    $display("test stall done");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    // The tests need about 100,000 cycles; the limit leaves a fifth again.
    #1200000;
    n_errors++;
    end_of_test();
  end

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_kind = XFER_WRITE_BYTE;
    cmd_addr = 7'h00;
    cmd_ptr = 8'h00;
    cmd_wdata = 16'h0000;
    conv_data = 9'h000;
    conv_valid = 1'b0;
    ext_reset_n = 1'b1;
    n_errors = 0;
    n_checks = 0;
    repeat (16) @(posedge clk);
    #1;
    rst_n = 1'b1;
    check1("shutdown after reset", 1'b0, shutdown_out);
    t_wrong_addr();
    t_temp_read();
    t_fault_six();
    t_cfg_read();
    t_ext_reset();
    t_stall();
    end_of_test();
  end
endmodule // testbench
